//--- design/violation_regs_pkg.sv
package violation_regs_pkg;

  // register offsets (byte addresses)
  localparam logic [11:0] RAM_EVENT_OFS = 12'h0100;
  localparam logic [11:0] FLASH_EVENT_OFS = 12'h0104;
  localparam logic [11:0] PERIPH_EVENT_OFS = 12'h0108;
  localparam logic [11:0] RAM_PUBLISH_OFS = 12'h0180;
  localparam logic [11:0] FLASH_PUBLISH_OFS = 12'h0184;
  localparam logic [11:0] PERIPH_PUBLISH_OFS = 12'h0188;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h0300;
  localparam logic [11:0] IRQ_ENABLE_SET_OFS = 12'h0304;
  localparam logic [11:0] IRQ_ENABLE_CLEAR_OFS = 12'h0308;

  // widths and field positions
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 3;
  localparam int CHANNEL_W = 16;
  localparam int CHANNEL_LSB = 0;
  localparam int PUBLISH_EN_BIT = 31;
  localparam int EVENT_BIT = 0;

  // source index, also the bit position in the enable registers
  localparam int SRC_RAM = 0;
  localparam int SRC_FLASH = 1;
  localparam int SRC_PERIPH = 2;

  // values after reset
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] PUBLISH_RESET = 32'h0000_0000;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // one published event toward the event interconnect
  typedef struct packed {
    logic valid;
    logic [CHANNEL_W-1:0] channel;
  } publish_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

endpackage

//--- design/violation_event_flag.sv
`timescale 1ns/1ns
module violation_event_flag
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // detection and software write
  input wire logic detect_i,
  input wire logic wr_i,
  input wire logic wdata_i,
  // latched flag
  output logic flag_o
);

  logic flag_reg;
  logic flag_next;

  // detection wins over a clearing write in the same cycle
  always_comb
  begin
    flag_next = flag_reg;
    if (wr_i)
    begin
      flag_next = wdata_i;
    end
    if (detect_i)
    begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flag_reg <= violation_regs_pkg::EVENT_RESET[violation_regs_pkg::EVENT_BIT];
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;

endmodule

//--- design/violation_publisher.sv
`timescale 1ns/1ns
module violation_publisher
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // configuration write
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  // detection
  input wire logic detect_i,
  // configuration readback and published event
  output logic [31:0] config_o,
  output violation_regs_pkg::publish_t publish_o
);

  logic enable_reg;
  logic [violation_regs_pkg::CHANNEL_W-1:0] channel_reg;
  violation_regs_pkg::publish_t publish_reg;

  // channel index and enable bit
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      enable_reg <= violation_regs_pkg::PUBLISH_RESET[violation_regs_pkg::PUBLISH_EN_BIT];
      channel_reg <= violation_regs_pkg::PUBLISH_RESET[violation_regs_pkg::CHANNEL_W-1:0];
    end
    else if (wr_i)
    begin
      enable_reg <= wdata_i[violation_regs_pkg::PUBLISH_EN_BIT];
      channel_reg <= wdata_i[violation_regs_pkg::CHANNEL_LSB +: violation_regs_pkg::CHANNEL_W];
    end
  end

  // one-cycle broadcast on the selected channel, only while enabled
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      publish_reg <= '0;
    end
    else
    begin
      publish_reg.valid <= detect_i && enable_reg;
      publish_reg.channel <= channel_reg;
    end
  end

  always_comb
  begin
    config_o = 32'h0000_0000;
    config_o[violation_regs_pkg::PUBLISH_EN_BIT] = enable_reg;
    config_o[violation_regs_pkg::CHANNEL_LSB +: violation_regs_pkg::CHANNEL_W] = channel_reg;
  end

  assign publish_o = publish_reg;

endmodule

//--- design/security_violation_event_regs.sv
// What this block does
// - a ram violation sets a flag at offset 0x100 that reads 1 until cleared and resets to 0.
// - a flash violation sets a flag at offset 0x104.
// - a violation on any peripheral sets a flag at offset 0x108.
// - the ram publish register at 0x180 holds a writable channel index in bits 15..0.
// - the flash publish register at 0x184 holds a channel index and an enable in bit 31.
// - the peripheral publish register at 0x188 does likewise; all three reset to 0, disabled.
// - the enable register at 0x300 has bit 0 ram, bit 1 flash, bit 2 peripheral.
// - writing 1 to a bit at 0x304 sets that enable and leaves the others alone.
// - reading 0x304 returns the current enables.
// - writing 1 to a bit at 0x308 clears that enable; reading it returns the enables.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module security_violation_event_regs
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [violation_regs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [violation_regs_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [violation_regs_pkg::DATA_W-1:0] rd_data_o,
  // violation detections, one-cycle pulses
  input wire logic ram_violation_i,
  input wire logic flash_violation_i,
  input wire logic periph_violation_i,
  // published events
  output violation_regs_pkg::publish_t ram_violation_publish_o,
  output violation_regs_pkg::publish_t flash_violation_publish_o,
  output violation_regs_pkg::publish_t periph_violation_publish_o,
  // interrupt
  output logic irq_o
);

  localparam int NUM_SRC = violation_regs_pkg::NUM_SRC;

  violation_regs_pkg::bus_req_t req;
  logic [NUM_SRC-1:0] detect;
  logic [NUM_SRC-1:0] event_wr;
  logic [NUM_SRC-1:0] publish_wr;
  logic [NUM_SRC-1:0] flag;
  logic [31:0] publish_cfg [NUM_SRC];
  violation_regs_pkg::publish_t publish [NUM_SRC];
  logic [NUM_SRC-1:0] irq_enable_reg;
  logic [NUM_SRC-1:0] irq_enable_next;
  logic [violation_regs_pkg::DATA_W-1:0] rd_data_reg;
  logic [violation_regs_pkg::DATA_W-1:0] rd_data_next;
  logic irq_reg;
  logic irq_next;

  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign req.addr = addr_i;
  assign req.wdata = wdata_i;

  assign detect[violation_regs_pkg::SRC_RAM] = ram_violation_i;
  assign detect[violation_regs_pkg::SRC_FLASH] = flash_violation_i;
  assign detect[violation_regs_pkg::SRC_PERIPH] = periph_violation_i;

  // write decode of the per-source registers
  always_comb
  begin
    event_wr = '0;
    publish_wr = '0;
    if (req.wr)
    begin
      unique case (req.addr)
        violation_regs_pkg::RAM_EVENT_OFS:
          event_wr[violation_regs_pkg::SRC_RAM] = 1'b1;
        violation_regs_pkg::FLASH_EVENT_OFS:
          event_wr[violation_regs_pkg::SRC_FLASH] = 1'b1;
        violation_regs_pkg::PERIPH_EVENT_OFS:
          event_wr[violation_regs_pkg::SRC_PERIPH] = 1'b1;
        violation_regs_pkg::RAM_PUBLISH_OFS:
          publish_wr[violation_regs_pkg::SRC_RAM] = 1'b1;
        violation_regs_pkg::FLASH_PUBLISH_OFS:
          publish_wr[violation_regs_pkg::SRC_FLASH] = 1'b1;
        violation_regs_pkg::PERIPH_PUBLISH_OFS:
          publish_wr[violation_regs_pkg::SRC_PERIPH] = 1'b1;
        default:
        begin
          event_wr = '0;
          publish_wr = '0;
        end
      endcase
    end
  end

  // one flag and one publisher per source
  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_src
    violation_event_flag u_flag
    (
      .clk_sys_i (clk_sys_i),
      .rst_b_i (rst_b_i),
      .detect_i (detect[i]),
      .wr_i (event_wr[i]),
      .wdata_i (req.wdata[violation_regs_pkg::EVENT_BIT]),
      .flag_o (flag[i])
    );

    violation_publisher u_pub
    (
      .clk_sys_i (clk_sys_i),
      .rst_b_i (rst_b_i),
      .wr_i (publish_wr[i]),
      .wdata_i (req.wdata),
      .detect_i (detect[i]),
      .config_o (publish_cfg[i]),
      .publish_o (publish[i])
    );
  end

  assign ram_violation_publish_o = publish[violation_regs_pkg::SRC_RAM];
  assign flash_violation_publish_o = publish[violation_regs_pkg::SRC_FLASH];
  assign periph_violation_publish_o = publish[violation_regs_pkg::SRC_PERIPH];

  // interrupt enable: direct write, set alias, clear alias
  always_comb
  begin
    irq_enable_next = irq_enable_reg;
    if (req.wr)
    begin
      unique case (req.addr)
        violation_regs_pkg::IRQ_ENABLE_OFS:
          irq_enable_next = req.wdata[NUM_SRC-1:0];
        violation_regs_pkg::IRQ_ENABLE_SET_OFS:
          irq_enable_next = irq_enable_reg | req.wdata[NUM_SRC-1:0];
        violation_regs_pkg::IRQ_ENABLE_CLEAR_OFS:
          irq_enable_next = irq_enable_reg & ~req.wdata[NUM_SRC-1:0];
        default:
          irq_enable_next = irq_enable_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_enable_reg <= violation_regs_pkg::IRQ_ENABLE_RESET;
    end
    else
    begin
      irq_enable_reg <= irq_enable_next;
    end
  end

  // interrupt level from flags gated by enables
  always_comb
  begin
    irq_next = |(flag & irq_enable_reg);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // read mux, data in the cycle after the strobe only
  always_comb
  begin
    rd_data_next = violation_regs_pkg::READ_UNMAPPED;
    if (req.rd)
    begin
      unique case (req.addr)
        violation_regs_pkg::RAM_EVENT_OFS:
          rd_data_next[violation_regs_pkg::EVENT_BIT] = flag[violation_regs_pkg::SRC_RAM];
        violation_regs_pkg::FLASH_EVENT_OFS:
          rd_data_next[violation_regs_pkg::EVENT_BIT] = flag[violation_regs_pkg::SRC_FLASH];
        violation_regs_pkg::PERIPH_EVENT_OFS:
          rd_data_next[violation_regs_pkg::EVENT_BIT] = flag[violation_regs_pkg::SRC_PERIPH];
        violation_regs_pkg::RAM_PUBLISH_OFS:
          rd_data_next = publish_cfg[violation_regs_pkg::SRC_RAM];
        violation_regs_pkg::FLASH_PUBLISH_OFS:
          rd_data_next = publish_cfg[violation_regs_pkg::SRC_FLASH];
        violation_regs_pkg::PERIPH_PUBLISH_OFS:
          rd_data_next = publish_cfg[violation_regs_pkg::SRC_PERIPH];
        violation_regs_pkg::IRQ_ENABLE_OFS,
        violation_regs_pkg::IRQ_ENABLE_SET_OFS,
        violation_regs_pkg::IRQ_ENABLE_CLEAR_OFS:
          rd_data_next[NUM_SRC-1:0] = irq_enable_reg;
        default:
          rd_data_next = violation_regs_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_reg <= violation_regs_pkg::READ_UNMAPPED;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule

//--- sim/publish_sink.sv
`timescale 1ns/1ns
module publish_sink
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // published event
  input wire violation_regs_pkg::publish_t pub_i,
  // observed traffic
  output int count_o,
  output logic [15:0] chan_o
);
  // counts pulses, keeps the last channel
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_o <= 0;
      chan_o <= 16'h0000;
    end
    else if (pub_i.valid)
    begin
      count_o <= count_o + 1;
      chan_o <= pub_i.channel;
    end
  end
endmodule

//--- sim/security_violation_event_regs_sva.sv
`timescale 1ns/1ns
module violation_regs_checker
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  // detections and outputs
  input wire logic ram_violation_i,
  input wire logic flash_violation_i,
  input wire logic periph_violation_i,
  input wire violation_regs_pkg::publish_t ram_violation_publish_o,
  input wire violation_regs_pkg::publish_t flash_violation_publish_o,
  input wire violation_regs_pkg::publish_t periph_violation_publish_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_rd(a); rd_i && addr_i == a; endsequence
  sequence s_wr(a, b); wr_i && addr_i == a && wdata_i[b]; endsequence
  sequence s_gap; ##1 !wr_i ##1 1'b1; endsequence
  property p_ram_flag; ram_violation_i ##0 s_gap ##0 s_rd(12'h0100) |=> rd_data_o == 32'h0000_0001;
  endproperty
  a_ram_flag: assert property (p_ram_flag) else $error("ram flag not read back");
  property p_pub_ram; ram_violation_publish_o.valid |-> $past(ram_violation_i); endproperty
  a_pub_ram: assert property (p_pub_ram) else $error("ram publish without cause");
  property p_pub_flash; flash_violation_publish_o.valid |-> $past(flash_violation_i); endproperty
  a_pub_flash: assert property (p_pub_flash) else $error("flash publish without cause");
  property p_pub_per; periph_violation_publish_o.valid |-> $past(periph_violation_i); endproperty
  a_pub_per: assert property (p_pub_per) else $error("periph publish without cause");
  property p_en_bits; s_rd(12'h0300) |=> rd_data_o[31:3] == 29'h0000_0000; endproperty
  a_en_bits: assert property (p_en_bits) else $error("enable upper bits set");
  property p_set; s_wr(12'h0304, 0) ##0 s_gap ##0 s_rd(12'h0300) |=> rd_data_o[0]; endproperty
  a_set: assert property (p_set) else $error("set alias failed");
  property p_alias; s_rd(12'h0300) ##0 s_gap ##0 s_rd(12'h0304) |=> rd_data_o == $past(rd_data_o, 2);
  endproperty
  a_alias: assert property (p_alias) else $error("set alias read differs");
  property p_clr; s_wr(12'h0308, 1) ##0 s_gap ##0 s_rd(12'h0304) |=> !rd_data_o[1]; endproperty
  a_clr: assert property (p_clr) else $error("clear alias failed");
  property p_irq_rise;
    $rose(irq_o) |-> $past(wr_i, 2) || $past(ram_violation_i, 2) || $past(flash_violation_i, 2)
      || $past(periph_violation_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
endmodule

bind security_violation_event_regs violation_regs_checker u_chk
(
  .clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rd_data_o,
  .ram_violation_i, .flash_violation_i, .periph_violation_i, .ram_violation_publish_o,
  .flash_violation_publish_o, .periph_violation_publish_o, .irq_o
);

//--- sim/security_violation_event_regs_tb_top.sv
`timescale 1ns/1ns
module security_violation_event_regs_tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] addr = 12'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0] det = 3'h0;
  logic [31:0] rdata;
  logic irq;
  violation_regs_pkg::publish_t pub [3];
  int cnt [3];
  logic [15:0] ch [3];
  int n_fail = 0;
  int num_checks = 0;
  row_t rows [9] = '{'{12'h0180, 32'hFFFF_FFFF, 32'h8000_FFFF},
    '{12'h0184, 32'h8000_1234, 32'h8000_1234}, '{12'h0188, 32'h7FFF_00AB, 32'h0000_00AB},
    '{12'h0300, 32'hFFFF_FFFD, 32'h0000_0005}, '{12'h0304, 32'h0000_0002, 32'h0000_0007},
    '{12'h0308, 32'h0000_0001, 32'h0000_0006}, '{12'h0304, 32'h0000_0000, 32'h0000_0006},
    '{12'h000C, 32'hFFFF_FFFF, 32'h0000_0000}, '{12'h0104, 32'hFFFF_FFFF, 32'h0000_0001}};

  always #2 clk = ~clk;

  security_violation_event_regs uut
  (
    .clk_sys_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdata), .ram_violation_i(det[0]), .flash_violation_i(det[1]),
    .periph_violation_i(det[2]), .ram_violation_publish_o(pub[0]),
    .flash_violation_publish_o(pub[1]), .periph_violation_publish_o(pub[2]), .irq_o(irq)
  );

  for (genvar i = 0; i < 3; i++)
  begin : g_sink
    publish_sink u_sink
    (
      .clk_sys_i(clk), .rst_b_i(rst_b), .pub_i(pub[i]), .count_o(cnt[i]), .chan_o(ch[i])
    );
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // one bus access, then one idle cycle
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    #1;
    if (!w) chk("rd_data_o", e, rdata);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task pulse(input logic [2:0] v);
    det <= v;
    @(posedge clk);
    #1;
    det <= 3'h0;
    @(posedge clk);
    #1;
  endtask

  task finish_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_b <= 1'b1;
    foreach (rows[i]) acc(1'b0, rows[i].a, 0, 32'h0000_0000);
    foreach (rows[i])
    begin
      acc(1'b1, rows[i].a, rows[i].d, 0);
      acc(1'b0, rows[i].a, 0, rows[i].e);
    end
    chk("irq_o", 32'h0000_0001, {31'h0000_0000, irq});
    acc(1'b1, 12'h0104, 0, 0);
    chk("irq_o", 32'h0000_0000, {31'h0000_0000, irq});
    pulse(3'h7);
    chk("ram count", 32'h0000_0001, 32'(cnt[0]));
    chk("ram chan", 32'h0000_FFFF, {16'h0000, ch[0]});
    chk("flash count", 32'h0000_0001, 32'(cnt[1]));
    chk("flash chan", 32'h0000_1234, {16'h0000, ch[1]});
    chk("periph count", 32'h0000_0000, 32'(cnt[2]));
    chk("irq_o", 32'h0000_0001, {31'h0000_0000, irq});
    acc(1'b0, 12'h0100, 0, 32'h0000_0001);
    acc(1'b0, 12'h0104, 0, 32'h0000_0001);
    acc(1'b0, 12'h0108, 0, 32'h0000_0001);
    acc(1'b1, 12'h0308, 32'h0000_0006, 0);
    chk("irq_o", 32'h0000_0000, {31'h0000_0000, irq});
    acc(1'b1, 12'h0304, 32'h0000_0001, 0);
    acc(1'b0, 12'h0300, 0, 32'h0000_0001);
    acc(1'b0, 12'h0304, 0, 32'h0000_0001);
    chk("irq_o", 32'h0000_0001, {31'h0000_0000, irq});
    acc(1'b1, 12'h0304, 32'h0000_0002, 0);
    acc(1'b1, 12'h0308, 32'h0000_0002, 0);
    acc(1'b0, 12'h0304, 0, 32'h0000_0001);
    acc(1'b1, 12'h0100, 0, 0);
    chk("irq_o", 32'h0000_0000, {31'h0000_0000, irq});
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    rst_b <= 1'b1;
    acc(1'b0, 12'h0184, 0, 32'h0000_0000);
    acc(1'b0, 12'h0104, 0, 32'h0000_0000);
    finish_test;
  end
endmodule
